// [rtl/dee_regs.vh]
`ifndef DEE_REGS_VH
`define DEE_REGS_VH

// Control/status register location in data space
`define DEE_CTL_ADDR      8'hDF
`define DEE_CTL_RESET     8'h00

// Control/status field positions
`define DEE_BIT_STANDBY   6
`define DEE_BIT_START     3
`define DEE_BIT_ROW_MODE  2
`define DEE_BIT_BUSY      1
`define DEE_BIT_ENABLE    0

// Array geometry and contents
`define DEE_ADDR_W        7
`define DEE_ROW_BYTES     8
`define DEE_ERASED        8'hFF
`define DEE_DEAD_READ     8'h00

// Programming cycle length in clock cycles
`define DEE_PROG_CYCLES   1000

`endif

// [rtl/dee_ctrl.v]
`include "dee_regs.vh"

module dee_ctrl #(
  parameter AW          = `DEE_ADDR_W,
  parameter PROG_CYCLES = `DEE_PROG_CYCLES
) (
  input  wire          clock,
  input  wire          resetn,
  input  wire [7:0]    bus_addr,
  input  wire [7:0]    bus_wdata,
  input  wire          bus_wr,
  input  wire          bus_rd,
  input  wire          ee_sel,
  input  wire [AW-1:0] ee_addr,
  output reg  [7:0]    bus_rdata_r,
  output reg           program_busy_r,
  output reg           array_standby_r
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_BYTE = 3'b010;
  localparam [2:0] ST_ROW  = 3'b100;
  localparam integer LAST_INT = PROG_CYCLES - 1;
  localparam [15:0]  LAST_CNT = LAST_INT[15:0];

  reg [7:0]    mem [0:(1<<AW)-1];
  wire [8*`DEE_ROW_BYTES-1:0] row_flat;
  reg [7:0]    row_mask_r;
  reg          row_addr_valid_r;
  reg [AW-4:0] row_addr_r;
  reg [2:0]    state_r;
  reg [15:0]   cnt_r;
  reg          program_enable_r;
  reg          row_mode_enable_r;
  reg          row_write_start_r;
  reg [AW-1:0] byte_addr_r;
  reg [7:0]    byte_data_r;

  wire ctl_wr;
  wire ctl_rd;
  wire ee_wr;
  wire ee_rd;
  wire row_hit;
  wire done;

  function is_ctl;
    input [7:0] a;
    begin
      is_ctl = (a == `DEE_CTL_ADDR);
    end
  endfunction

  // Array access gated by standby and busy
  assign ctl_wr  = bus_wr & ~ee_sel & is_ctl(bus_addr);
  assign ctl_rd  = bus_rd & ~ee_sel & is_ctl(bus_addr);
  assign ee_wr   = bus_wr & ee_sel & ~program_busy_r & ~array_standby_r;
  assign ee_rd   = bus_rd & ee_sel & ~program_busy_r & ~array_standby_r;
  assign row_hit = ~row_addr_valid_r | (row_addr_r == ee_addr[AW-1:3]);
  assign done    = (state_r != ST_IDLE) & (cnt_r == 16'h0000);

  integer i;
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      mem[i] = `DEE_ERASED;
    end
  end

  // Array programming at cycle end
  integer k;
  always @(posedge clock) begin
    if (done && state_r == ST_BYTE) begin
      mem[byte_addr_r] <= byte_data_r;
    end
    if (done && state_r == ST_ROW && row_write_start_r) begin
      for (k = 0; k < `DEE_ROW_BYTES; k = k + 1) begin
        if (row_mask_r[k]) begin
          mem[{row_addr_r, k[2:0]}] <= row_flat[k*8 +: 8];
        end
      end
    end
  end

  // Row latch data
  genvar g;
  generate
    for (g = 0; g < `DEE_ROW_BYTES; g = g + 1) begin : g_latch
      reg [7:0] lat_r;
      // One latch byte per row slot
      assign row_flat[g*8 +: 8] = lat_r;
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          lat_r <= 8'h00;
        end else if (ctl_wr && !program_busy_r && bus_wdata[`DEE_BIT_ROW_MODE] && !row_mode_enable_r) begin
          lat_r <= 8'h00;
        end else if (ee_wr && row_mode_enable_r && row_hit && ee_addr[2:0] == g) begin
          lat_r <= bus_wdata;
        end
      end
    end
  endgenerate

  // Control, sequencing and status
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_r           <= ST_IDLE;
      cnt_r             <= 16'h0000;
      program_enable_r  <= 1'b0;
      row_mode_enable_r <= 1'b0;
      row_write_start_r <= 1'b0;
      array_standby_r   <= 1'b0;
      program_busy_r    <= 1'b0;
      row_mask_r        <= 8'h00;
      row_addr_valid_r  <= 1'b0;
      row_addr_r        <= {(AW-3){1'b0}};
      byte_addr_r       <= {AW{1'b0}};
      byte_data_r       <= 8'h00;
      bus_rdata_r       <= `DEE_DEAD_READ;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (ctl_wr) begin
            array_standby_r  <= bus_wdata[`DEE_BIT_STANDBY];
            program_enable_r <= bus_wdata[`DEE_BIT_ENABLE];
            if (bus_wdata[`DEE_BIT_ROW_MODE] && !row_mode_enable_r) begin
              row_mode_enable_r <= 1'b1;
              row_mask_r        <= 8'h00;
              row_addr_valid_r  <= 1'b0;
            end else if (!bus_wdata[`DEE_BIT_ROW_MODE]) begin
              row_mode_enable_r <= 1'b0;
              row_mask_r        <= 8'h00;
              row_addr_valid_r  <= 1'b0;
            end
            // start needs enable and row mode
            if (bus_wdata[`DEE_BIT_START] && program_enable_r && row_mode_enable_r &&
                bus_wdata[`DEE_BIT_ROW_MODE]) begin
              row_write_start_r <= 1'b1;
              program_busy_r    <= 1'b1;
              cnt_r             <= LAST_CNT;
              state_r           <= ST_ROW;
            end
          end else if (ee_wr && row_mode_enable_r) begin
            if (row_hit) begin
              row_addr_valid_r       <= 1'b1;
              row_addr_r             <= ee_addr[AW-1:3];
              row_mask_r[ee_addr[2:0]] <= 1'b1;
            end
          end else if (ee_wr && program_enable_r) begin
            byte_addr_r    <= ee_addr;
            byte_data_r    <= bus_wdata;
            program_busy_r <= 1'b1;
            cnt_r          <= LAST_CNT;
            state_r        <= ST_BYTE;
          end
        end
        ST_BYTE, ST_ROW: begin
          if (cnt_r != 16'h0000) begin
            cnt_r <= cnt_r - 16'h0001;
          end else begin
            program_busy_r <= 1'b0;
            state_r        <= ST_IDLE;
            if (state_r == ST_ROW) begin
              row_write_start_r <= 1'b0;
              row_mode_enable_r <= 1'b0;
              row_mask_r        <= 8'h00;
              row_addr_valid_r  <= 1'b0;
            end
          end
        end
        default: begin
          state_r        <= ST_IDLE;
          program_busy_r <= 1'b0;
        end
      endcase

      // Read data path
      if (ctl_rd) begin
        bus_rdata_r <= {6'b000000, program_busy_r, 1'b0};
      end else if (ee_rd && !row_mode_enable_r) begin
        bus_rdata_r <= mem[ee_addr];
      end else if (bus_rd) begin
        bus_rdata_r <= `DEE_DEAD_READ;
      end
    end
  end

endmodule // dee_ctrl

// [bench/dee_ctrl_properties.sv]
module dee_ctrl_properties #(
  parameter PROG_CYCLES = 1000
) (
  input logic       clock,
  input logic       resetn,
  input logic [7:0] bus_addr,
  input logic [7:0] bus_wdata,
  input logic       bus_wr,
  input logic       bus_rd,
  input logic       ee_sel,
  input logic [6:0] ee_addr,
  input logic [7:0] bus_rdata_r,
  input logic       program_busy_r,
  input logic       array_standby_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  logic ctl_hit, ctl_wr, en_r;
  int   cnt_r;
  assign ctl_hit = !ee_sel && bus_addr == 8'hDF;
  assign ctl_wr = bus_wr && ctl_hit && !program_busy_r;
  // Enable copy and busy length
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_r <= 1'b0;
      cnt_r <= 0;
    end else begin
      if (ctl_wr) en_r <= bus_wdata[0];
      cnt_r <= program_busy_r ? cnt_r + 1 : 0;
    end
  end
  sequence ctl_rd_s;
    bus_rd && ctl_hit;
  endsequence
  sequence arr_rd_s;
    bus_rd && ee_sel;
  endsequence
  busy_length_a: assert property ($fell(program_busy_r) |-> cnt_r == PROG_CYCLES)
    else $error("busy length wrong");
  no_enable_a: assert property (bus_wr && ee_sel && !en_r && !program_busy_r |=> !program_busy_r)
    else $error("write without enable");
  start_refused_a: assert property (ctl_wr && !en_r |=> !program_busy_r)
    else $error("start accepted");
  busy_read_a: assert property (arr_rd_s and program_busy_r |=> bus_rdata_r == 8'h00)
    else $error("read while busy");
  status_read_a: assert property (ctl_rd_s |=> bus_rdata_r == {6'h00, $past(program_busy_r), 1'b0})
    else $error("status read wrong");
  standby_set_a: assert property (ctl_wr |=> array_standby_r == $past(bus_wdata[6]))
    else $error("standby not taken");
  standby_read_a: assert property (arr_rd_s and array_standby_r |=> bus_rdata_r == 8'h00)
    else $error("read in standby");
  ctl_locked_a: assert property (bus_wr && ctl_hit && program_busy_r |=> $stable(array_standby_r))
    else $error("control write while busy");
endmodule // dee_ctrl_properties

bind dee_ctrl dee_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.clock, .resetn, .bus_addr,
  .bus_wdata, .bus_wr, .bus_rd, .ee_sel, .ee_addr, .bus_rdata_r, .program_busy_r, .array_standby_r);

// [bench/dee_cpu_model.sv]
module dee_cpu_model (
  input  logic       clock,
  input  logic       busy,
  output logic [7:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic       bus_wr,
  output logic       bus_rd,
  output logic       ee_sel,
  output logic [6:0] ee_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] exp_q[$];
  initial {bus_addr, bus_wdata, bus_wr, bus_rd, ee_sel, ee_addr} = '0;
  task automatic wr(input logic s, input logic [7:0] a, input logic [7:0] d, input logic w = 1);
    @(posedge clock);
    #1 {bus_wr, bus_rd, ee_sel, bus_addr, ee_addr, bus_wdata} = {w, !w, s, a, a[6:0], d};
    @(posedge clock);
    #1 {bus_wr, bus_rd} = 2'b00;
    {bus_addr, ee_addr, bus_wdata} = ~{bus_addr, ee_addr, bus_wdata};
  endtask
  task automatic rd(input logic s, input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    wr(s, a, 8'h00, 1'b0);
  endtask
  task automatic idle;
    for (int n = 0; n < 40; n++) begin
      @(posedge clock);
      #1 if (busy === 1'b0) break;
    end
  endtask
endmodule // dee_cpu_model

// [bench/tb_data_eeprom_write_control.sv]
module tb_data_eeprom_write_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 0, resetn = 0, rd_d = 0;
  logic [7:0] bus_addr, bus_wdata, bus_rdata_r, d[4];
  logic [7:0] ra[3] = '{8'h18, 8'h1A, 8'h1B};
  logic       bus_wr, bus_rd, ee_sel, program_busy_r, array_standby_r;
  logic [6:0] ee_addr;
  int         err_count = 0, compares = 0, seed = 32'hFAB0D6BA;
  always #2.5 clock = ~clock;
  dee_ctrl #(.PROG_CYCLES(16)) dut_u (.clock, .resetn, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .ee_sel, .ee_addr, .bus_rdata_r, .program_busy_r, .array_standby_r);
  dee_cpu_model cpu_u (.clock, .busy(program_busy_r), .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
    .ee_sel, .ee_addr);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Read answers against oldest note
  always @(posedge clock) begin
    if (rd_d) chk(bus_rdata_r, cpu_u.exp_q.pop_front(), "read data");
    rd_d <= bus_rd;
  end
  initial begin
    #20000 err_count++;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 resetn = 1;
    foreach (d[i]) d[i] = $random(seed);
    cpu_u.rd(0, 8'hDF, 8'h00);
    cpu_u.rd(1, 8'h05, 8'hFF);
    cpu_u.wr(1, 8'h05, d[0]);
    cpu_u.rd(1, 8'h05, 8'hFF);
    cpu_u.rd(0, 8'hDF, 8'h00);
    cpu_u.wr(0, 8'hDF, 8'h01);
    cpu_u.wr(1, 8'h05, d[0]);
    cpu_u.rd(1, 8'h05, 8'h00);
    cpu_u.rd(0, 8'hDF, 8'h02);
    cpu_u.wr(0, 8'hDF, 8'h40);
    chk({7'h00, array_standby_r}, 8'h00, "standby");
    cpu_u.idle;
    chk({7'h00, program_busy_r}, 8'h00, "busy");
    cpu_u.rd(1, 8'h05, d[0]);
    cpu_u.wr(0, 8'hDF, 8'h05);
    foreach (ra[i]) cpu_u.wr(1, ra[i], d[i + 1]);
    cpu_u.wr(1, 8'h20, d[0]);
    cpu_u.wr(0, 8'hDF, 8'h0D);
    cpu_u.idle;
    chk({7'h00, program_busy_r}, 8'h00, "busy");
    foreach (ra[i]) cpu_u.rd(1, ra[i], d[i + 1]);
    cpu_u.rd(1, 8'h19, 8'hFF);
    cpu_u.rd(1, 8'h20, 8'hFF);
    cpu_u.wr(0, 8'hDF, 8'h09);
    cpu_u.rd(0, 8'hDF, 8'h00);
    cpu_u.wr(0, 8'hDF, 8'h05);
    cpu_u.wr(1, 8'h28, d[1]);
    cpu_u.wr(0, 8'hDF, 8'h01);
    cpu_u.wr(0, 8'hDF, 8'h0D);
    cpu_u.rd(0, 8'hDF, 8'h00);
    cpu_u.wr(0, 8'hDF, 8'h01);
    cpu_u.rd(1, 8'h28, 8'hFF);
    cpu_u.wr(0, 8'hDF, 8'h40);
    chk({7'h00, array_standby_r}, 8'h01, "standby");
    cpu_u.rd(1, 8'h05, 8'h00);
    cpu_u.wr(0, 8'hDF, 8'h00);
    cpu_u.rd(1, 8'h05, d[0]);
    repeat (2) @(posedge clock);
    test_done;
  end
endmodule // tb_data_eeprom_write_control
